// ---- src/sep_port.sv ----
// serial port logic of a dual-mode byte-wide eeprom
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Function
// - start in stream mode; a valid SCL falling edge switches to two-wire
// - two-wire mode is sticky until the next power-up reset
// - stream bytes are eight bits followed by one released null bit
// - one stream bit per rising stream clock edge, MSB first
// - stream walks addresses upward and wraps past the last location
// - nine sync edges with SDA released; tenth edge drives first MSB
// - stream start address is a parameter, not assumed zero
// - in two-wire mode stream clock is only a write-enable level
// - SDA falling while SCL high is a Start
// - SDA rising while SCL high is a Stop
// - SDA changes only while SCL low; one SCL pulse per bit
// - receiver holds SDA low through the ninth clock high phase
// - acknowledge only a matching address when no write is running
// - address byte: upper four type code, three ignored, last read/write
// - master no-acknowledge ends a read; slave releases SDA
// - byte write: address, pointer, data acknowledged; Stop programs
// - no acknowledges at all during the self-timed write cycle
// - enable held high during transfer; started programming completes
// - page buffer of eight; lower three bits wrap; Stop programs
module sep_port #(
  parameter int                        WR_CYCLES  = sep_pkg::WR_CYCLES,
  parameter logic [sep_pkg::ADDR_W-1:0] START_ADDR = sep_pkg::ADDR_RST
) (
  // system clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // stream clock, also the write-enable level in two-wire mode
  input  wire logic stream_clock_write_enable_pin_i,
  // two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // status
  output logic      bidir_mode_o,
  output logic      write_busy_o
);

  // ==========================================================================
  // state registers
  sep_pkg::sep_sys_s  s_r;
  sep_pkg::sep_sys_s  s_nxt;
  sep_pkg::sep_strm_s t_r;
  sep_pkg::sep_strm_s t_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;

  assign scl_rise  = s_r.scl_s & ~s_r.scl_p;
  assign scl_fall  = ~s_r.scl_s & s_r.scl_p;
  assign start_det = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
  assign stop_det  = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
  assign busy      = s_r.tmr != '0;

  // ==========================================================================
  // stream-clock domain: transmit-only stream
  always_comb begin
    t_nxt       = t_r;
    t_nxt.rst_m = rst_i;
    t_nxt.rst_s = t_r.rst_m;
    t_nxt.ack_m = s_r.ack_t;
    t_nxt.ack_s = t_r.ack_m;
    if (t_r.rst_s) begin
      t_nxt.running  = 1'b0;
      t_nxt.init_cnt = 4'h0;
      t_nxt.bitn     = 4'h0;
      t_nxt.shift    = sep_pkg::BYTE_RST;
      t_nxt.oe       = 1'b0;
      t_nxt.addr     = START_ADDR;
      t_nxt.req_t    = 1'b0;
      t_nxt.ack_seen = 1'b0;
      t_nxt.buf_q    = sep_pkg::BYTE_RST;
    end else begin
      // fetched byte arrives via toggle handshake; data is stable by then
      if (t_r.ack_s != t_r.ack_seen) begin
        t_nxt.ack_seen = t_r.ack_s;
        t_nxt.buf_q    = s_r.rd_data;
      end
      if (!t_r.running) begin
        t_nxt.init_cnt = t_r.init_cnt + 4'h1;
        t_nxt.oe       = 1'b0;
        if (t_r.init_cnt == 4'h0) begin
          // first fetch overlaps the sync edges
          t_nxt.req_t = ~t_r.req_t;
        end
        if (t_r.init_cnt == sep_pkg::INIT_EDGES) begin
          // tenth edge: first MSB out
          t_nxt.running = 1'b1;
          t_nxt.shift   = t_r.buf_q;
          t_nxt.oe      = ~t_r.buf_q[7];
          t_nxt.bitn    = 4'h0;
          t_nxt.addr    = t_r.addr + 7'h01;
          t_nxt.req_t   = ~t_r.req_t;
        end
      end else if (t_r.bitn == sep_pkg::BIT_NULL) begin
        t_nxt.shift = t_r.buf_q;
        t_nxt.oe    = ~t_r.buf_q[7];
        t_nxt.bitn  = 4'h0;
        // wraps naturally at the top of the array
        t_nxt.addr  = t_r.addr + 7'h01;
        t_nxt.req_t = ~t_r.req_t;
      end else if (t_r.bitn == sep_pkg::BIT_LAST) begin
        t_nxt.oe   = 1'b0;
        t_nxt.bitn = sep_pkg::BIT_NULL;
      end else begin
        t_nxt.shift = {t_r.shift[6:0], 1'b0};
        t_nxt.oe    = ~t_r.shift[6];
        t_nxt.bitn  = t_r.bitn + 4'h1;
      end
    end
  end

  always_ff @(posedge stream_clock_write_enable_pin_i) begin
    t_r <= t_nxt;
  end

  // ==========================================================================
  // system-clock domain: mode switch, fetch service, two-wire slave
  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_m = scl_i;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.we_m  = stream_clock_write_enable_pin_i;
    s_nxt.we_s  = s_r.we_m;
    s_nxt.req_m = t_r.req_t;
    s_nxt.req_s = s_r.req_m;
    s_nxt.req_p = s_r.req_s;

    // stream fetch: address is held steady while its toggle is pending
    if (s_r.req_s != s_r.req_p) begin
      s_nxt.rd_data = s_r.mem[t_r.addr];
      s_nxt.ack_t   = ~s_r.ack_t;
    end

    // self-timed write cycle; runs to the end whatever the enable does
    if (busy) begin
      s_nxt.tmr = s_r.tmr - sep_pkg::sep_tmr_t'(1);
    end

    if (!s_r.bidir) begin
      // only a clean SCL fall leaves stream mode, and only reset returns
      if (scl_fall) begin
        s_nxt.bidir = 1'b1;
      end
    end else if (start_det) begin
      // a Start abandons an unfinished page without programming it
      s_nxt.state = sep_pkg::ST_ADDR;
      s_nxt.bitn  = 4'h0;
      s_nxt.oe    = 1'b0;
      s_nxt.pval  = '0;
    end else if (stop_det) begin
      s_nxt.state = sep_pkg::ST_IDLE;
      s_nxt.oe    = 1'b0;
      s_nxt.pval  = '0;
      if (s_r.pval != '0 && s_r.we_ok && s_r.we_s) begin
        for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
          if (s_r.pval[i]) begin
            s_nxt.mem[{s_r.page, 3'(i)}] = s_r.pbuf[i];
          end
        end
        s_nxt.tmr = sep_pkg::sep_tmr_t'(WR_CYCLES);
      end
    end else begin
      case (s_r.state)
        sep_pkg::ST_ADDR, sep_pkg::ST_WADDR, sep_pkg::ST_WDATA: begin
          if (scl_rise) begin
            s_nxt.sh   = {s_r.sh[6:0], s_r.sda_s};
            s_nxt.bitn = s_r.bitn + 4'h1;
            if (s_r.state == sep_pkg::ST_WDATA && !s_r.we_s) begin
              s_nxt.we_ok = 1'b0;
            end
          end else if (scl_fall && s_r.bitn == sep_pkg::BITS_BYTE) begin
            if (s_r.state == sep_pkg::ST_ADDR) begin
              // every address byte is decoded, matching or not
              if (s_r.sh[sep_pkg::DTYPE_HI:sep_pkg::DTYPE_LO]
                  == sep_pkg::DEV_TYPE && !busy) begin
                s_nxt.oe    = 1'b1;
                s_nxt.rw    = s_r.sh[sep_pkg::RW_BIT];
                s_nxt.state = sep_pkg::ST_ACK_A;
              end else begin
                s_nxt.state = sep_pkg::ST_IDLE;
              end
            end else if (s_r.state == sep_pkg::ST_WADDR) begin
              s_nxt.ptr   = s_r.sh[6:0];
              s_nxt.page  = s_r.sh[6:3];
              s_nxt.pidx  = s_r.sh[2:0];
              s_nxt.pval  = '0;
              s_nxt.we_ok = s_r.we_s;
              s_nxt.oe    = 1'b1;
              s_nxt.state = sep_pkg::ST_ACK_W;
            end else begin
              // ninth and later bytes overwrite the oldest entries
              s_nxt.pbuf[s_r.pidx] = s_r.sh;
              s_nxt.pval[s_r.pidx] = 1'b1;
              s_nxt.pidx           = s_r.pidx + 3'h1;
              s_nxt.ptr            = {s_r.page, s_r.pidx + 3'h1};
              s_nxt.oe             = 1'b1;
              s_nxt.state          = sep_pkg::ST_ACK_D;
            end
          end
        end
        sep_pkg::ST_ACK_A: begin
          if (scl_fall) begin
            s_nxt.bitn = 4'h0;
            if (s_r.rw) begin
              s_nxt.tx    = s_r.mem[s_r.ptr];
              s_nxt.oe    = ~s_r.mem[s_r.ptr][7];
              s_nxt.ptr   = s_r.ptr + 7'h01;
              s_nxt.state = sep_pkg::ST_RDATA;
            end else begin
              s_nxt.oe    = 1'b0;
              s_nxt.state = sep_pkg::ST_WADDR;
            end
          end
        end
        sep_pkg::ST_ACK_W, sep_pkg::ST_ACK_D: begin
          if (scl_fall) begin
            s_nxt.oe    = 1'b0;
            s_nxt.bitn  = 4'h0;
            s_nxt.state = sep_pkg::ST_WDATA;
          end
        end
        sep_pkg::ST_RDATA: begin
          if (scl_rise) begin
            s_nxt.bitn = s_r.bitn + 4'h1;
          end else if (scl_fall) begin
            if (s_r.bitn == sep_pkg::BITS_BYTE) begin
              s_nxt.oe    = 1'b0;
              s_nxt.state = sep_pkg::ST_RACK;
            end else begin
              s_nxt.tx = {s_r.tx[6:0], 1'b0};
              s_nxt.oe = ~s_r.tx[6];
            end
          end
        end
        sep_pkg::ST_RACK: begin
          if (scl_rise) begin
            s_nxt.nack = s_r.sda_s;
          end else if (scl_fall) begin
            s_nxt.bitn = 4'h0;
            if (s_r.nack) begin
              s_nxt.oe    = 1'b0;
              s_nxt.state = sep_pkg::ST_IDLE;
            end else begin
              s_nxt.tx    = s_r.mem[s_r.ptr];
              s_nxt.oe    = ~s_r.mem[s_r.ptr][7];
              s_nxt.ptr   = s_r.ptr + 7'h01;
              s_nxt.state = sep_pkg::ST_RDATA;
            end
          end
        end
        default: begin
          s_nxt.oe = 1'b0;
        end
      endcase
    end

    if (rst_i) begin
      s_nxt.ack_t   = 1'b0;
      s_nxt.rd_data = sep_pkg::BYTE_RST;
      s_nxt.bidir   = 1'b0;
      s_nxt.state   = sep_pkg::ST_IDLE;
      s_nxt.bitn    = 4'h0;
      s_nxt.sh      = sep_pkg::BYTE_RST;
      s_nxt.rw      = 1'b0;
      s_nxt.ptr     = sep_pkg::ADDR_RST;
      s_nxt.tx      = sep_pkg::BYTE_RST;
      s_nxt.nack    = 1'b1;
      s_nxt.oe      = 1'b0;
      s_nxt.pbuf    = '0;
      s_nxt.pval    = '0;
      s_nxt.page    = '0;
      s_nxt.pidx    = '0;
      s_nxt.we_ok   = 1'b0;
      s_nxt.tmr     = '0;
      s_nxt.mem     = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  // ==========================================================================
  // outputs: open drain, only ever pulled low
  // stream drive is cut by the mode flag, since its clock may stop
  assign sda_o        = 1'b0;
  assign sda_oe_o     = (t_r.oe & ~s_r.bidir) | (s_r.oe & s_r.bidir);
  assign bidir_mode_o = s_r.bidir;
  assign write_busy_o = busy;

endmodule // sep_port

`default_nettype wire

// ---- src/sep_pkg.sv ----
// constants and state types of the dual-mode serial eeprom port
package sep_pkg;

  // ==========================================================================
  // array and page geometry
  localparam int ADDR_W     = 7;
  localparam int MEM_DEPTH  = 128;
  localparam int PAGE_BYTES = 8;
  localparam int PIDX_W     = 3;
  localparam int PAGE_W     = 4;

  // ==========================================================================
  // stream framing: 8 data bits then one null bit, after 9 sync edges
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] BIT_NULL   = 4'h8;
  localparam logic [3:0] INIT_EDGES = 4'h9;

  // ==========================================================================
  // two-wire framing and address byte
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  // device-type code; the value is arbitrary
  localparam logic [3:0] DEV_TYPE   = 4'h6;
  localparam int         DTYPE_HI   = 7;
  localparam int         DTYPE_LO   = 4;
  localparam int         RW_BIT     = 0;

  // ==========================================================================
  // self-timed write cycle
  localparam int TWR_US    = 10000;
  localparam int CLK_MHZ   = 25;
  localparam int WR_CYCLES = TWR_US * CLK_MHZ;
  localparam int TMR_W     = 18;

  typedef logic [TMR_W-1:0] sep_tmr_t;

  // ==========================================================================
  // reset values
  localparam logic [7:0]        BYTE_RST  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;

  // ==========================================================================
  // two-wire slave states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_WADDR = 9'h008,
    ST_ACK_W = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_D = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } sep_state_e;

  // ==========================================================================
  // state of the system-clock domain
  typedef struct packed {
    logic                            scl_m;
    logic                            scl_s;
    logic                            scl_p;
    logic                            sda_m;
    logic                            sda_s;
    logic                            sda_p;
    logic                            we_m;
    logic                            we_s;
    logic                            req_m;
    logic                            req_s;
    logic                            req_p;
    logic                            ack_t;
    logic [7:0]                      rd_data;
    logic                            bidir;
    sep_state_e                      state;
    logic [3:0]                      bitn;
    logic [7:0]                      sh;
    logic                            rw;
    logic [ADDR_W-1:0]               ptr;
    logic [7:0]                      tx;
    logic                            nack;
    logic                            oe;
    logic [PAGE_BYTES-1:0][7:0]      pbuf;
    logic [PAGE_BYTES-1:0]           pval;
    logic [PAGE_W-1:0]               page;
    logic [PIDX_W-1:0]               pidx;
    logic                            we_ok;
    sep_tmr_t                        tmr;
    logic [MEM_DEPTH-1:0][7:0]       mem;
  } sep_sys_s;

  // ==========================================================================
  // state of the stream-clock domain
  typedef struct packed {
    logic                            rst_m;
    logic                            rst_s;
    logic                            running;
    logic [3:0]                      init_cnt;
    logic [3:0]                      bitn;
    logic [7:0]                      shift;
    logic                            oe;
    logic [ADDR_W-1:0]               addr;
    logic                            req_t;
    logic                            ack_m;
    logic                            ack_s;
    logic                            ack_seen;
    logic [7:0]                      buf_q;
  } sep_strm_s;

endpackage

// ---- bench/sep_port_checker.sv ----
// assertion checker bound to the dual-mode serial eeprom port
`timescale 1ns/10ps
`default_nettype none
module sep_port_checker #(
  parameter int WR_CYCLES = sep_pkg::WR_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic stream_clock_write_enable_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic bidir_mode_o,
  input wire logic write_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // length of the self-timed write, counted in clocks
  int busy_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !write_busy_o) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end
  // ==========================================================================
  // properties
  property p_mode_sticky;
    bidir_mode_o |=> bidir_mode_o;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky)
    else $error("mode lost");
  property p_mode_cause;
    $rose(bidir_mode_o) |-> !$past(scl_i, 1) && !$past(scl_i, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("bad switch");
  property p_change_low;
    bidir_mode_o && $past(bidir_mode_o) && $changed(sda_oe_o)
      |-> !scl_i && !$past(scl_i);
  endproperty
  a_change_low: assert property (p_change_low)
    else $error("sda moved");
  property p_ack_hold;
    bidir_mode_o && sda_oe_o && $rose(scl_i) |-> sda_oe_o [*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low not held");
  // open drain: whenever the pin is driven it must be driven low
  property p_drive_low;
    sda_oe_o |-> !sda_o;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("sda driven high");
  property p_busy_quiet;
    write_busy_o |-> !sda_oe_o && bidir_mode_o;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("busy drive");
  // tolerance of one clock on the end of the cycle
  property p_busy_len;
    $fell(write_busy_o) |-> busy_cnt_r inside {[WR_CYCLES-1:WR_CYCLES+1]};
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length");
  property p_busy_stop;
    $rose(write_busy_o) |-> $past(scl_i) && $past(sda_i);
  endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("no stop");
  property p_busy_we;
    $rose(write_busy_o) |-> $past(stream_clock_write_enable_pin_i);
  endproperty
  a_busy_we: assert property (p_busy_we)
    else $error("write locked");
endmodule // sep_port_checker

bind sep_port sep_port_checker #(.WR_CYCLES(WR_CYCLES)) u_sep_port_checker (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .stream_clock_write_enable_pin_i(stream_clock_write_enable_pin_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .bidir_mode_o(bidir_mode_o),
  .write_busy_o(write_busy_o)
);
`default_nettype wire

// ---- bench/sep_master.sv ----
// two-wire master and stream clock source facing the eeprom port
`timescale 1ns/10ps
`default_nettype none
module sep_master (
  // system clock and resolved data wire
  input  wire logic clk_i,
  input  wire logic sda_i,
  // bus and stream clock drive
  output logic      scl_o,
  output logic      sda_low_o,
  output logic      strm_clk_o
);
  logic run = 1'b1;
  logic lvl = 1'b1;
  // ==========================================================================
  // stream clock runs from power-up, so the sync edges come first
  initial begin
    strm_clk_o = 1'b0;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    #0.5;
    forever begin
      strm_clk_o = run ? ~strm_clk_o : lvl;
      #16;
    end
  end
  // ==========================================================================
  // bus cycles, all moves 5 ns after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  // start is cond(0,1), stop cond(1,0), mode switch cond(0,0)
  task automatic cond(input logic first, input logic last);
    scl_o = 1'b0;
    tick(5);
    sda_low_o = first;
    tick(5);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = last;
    tick(8);
  endtask
  task automatic put_bit(input logic b, output logic got);
    scl_o = 1'b0;
    tick(5);
    sda_low_o = ~b;
    tick(5);
    scl_o = 1'b1;
    tick(4);
    got = sda_i;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] b, input logic nb,
                          output logic [7:0] got, output logic ninth);
    for (int i = 7; i >= 0; i--) put_bit(b[i], got[i]);
    put_bit(nb, ninth);
  endtask
endmodule // sep_master
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking testbench of the dual-mode serial eeprom port
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
  fails++; $display("mismatch at %0t: %s", $time, msg); end end
module testbench;
  localparam int NS [4] = '{1, 10, 5, 2};
  logic clk_i, rst_i = 1'b1;
  wire logic scl_w, low_w, strm_w, sda_o_w, oe_w, bidir_w, busy_w, sda_w;
  int fails = 0, n_tests = 0, k;
  logic [31:0] seed = 32'h80a8;
  logic [7:0] mem_m [128];
  logic [63:0] samp;
  logic [7:0] g;
  logic a;
  assign sda_w = (oe_w ? sda_o_w : 1'b1) & ~low_w;
  sep_port #(.WR_CYCLES(200), .START_ADDR(7'h5d)) u_sep_port (
    .clk_i(clk_i), .rst_i(rst_i), .stream_clock_write_enable_pin_i(strm_w),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o_w), .sda_oe_o(oe_w),
    .bidir_mode_o(bidir_w), .write_busy_o(busy_w));
  sep_master u_sep_master (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w),
    .sda_low_o(low_w), .strm_clk_o(strm_w));
  // ==========================================================================
  // helpers
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic ctl(input logic [3:0] ty, input logic rw);
    logic [7:0] r;
    r = rnd();
    u_sep_master.put_byte({ty, r[2:0], rw}, 1'b1, g, a);
  endtask
  task automatic wr(input logic [7:0] wa, input int n, input logic en);
    logic [7:0] r;
    u_sep_master.lvl = en;
    u_sep_master.cond(1'b0, 1'b1);
    ctl(sep_pkg::DEV_TYPE, 1'b0);
    `CHK(a, 1'b0, "write address")
    u_sep_master.put_byte(wa, 1'b1, g, a);
    `CHK(a, 1'b0, "word address")
    for (int i = 0; i < n; i++) begin
      r = rnd();
      u_sep_master.put_byte(r, 1'b1, g, a);
      `CHK(a, 1'b0, "data ack")
      if (en) mem_m[{wa[6:3], 3'(wa[2:0] + i)}] = r;
    end
    u_sep_master.cond(1'b1, 1'b0);
  endtask
  task automatic rd(input logic [6:0] wa, input int n);
    u_sep_master.cond(1'b0, 1'b1);
    ctl(sep_pkg::DEV_TYPE, 1'b0);
    u_sep_master.put_byte({1'b1, wa}, 1'b1, g, a);
    u_sep_master.cond(1'b0, 1'b1);
    ctl(sep_pkg::DEV_TYPE, 1'b1);
    `CHK(a, 1'b0, "read address")
    for (int i = 0; i < n; i++) begin
      u_sep_master.put_byte(8'hff, 1'(i == n - 1), g, a);
      `CHK(g, mem_m[7'(wa + i)], "read data")
    end
    u_sep_master.cond(1'b1, 1'b0);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy_w !== 1'b0; i++) u_sep_master.tick(1);
    `CHK(busy_w, 1'b0, "write cycle stuck")
    u_sep_master.lvl = 1'b1;
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #3000000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    for (int i = 0; i < 128; i++) mem_m[i] = 8'h00;
    repeat (2) @(posedge clk_i);
    #5 rst_i = 1'b0;
    for (int i = 0; i < 64; i++) begin
      @(negedge strm_w);
      samp[i] = oe_w;
    end
    k = 0;
    while (k < 63 && samp[k] !== 1'b1) k++;
    `CHK(k inside {[11:14]}, 1'b1, "first stream bit")
    for (int j = 0; j < 36; j++) begin
      `CHK(samp[k+j], 1'(j % 9 != 8), "framing")
    end
    `CHK(bidir_w, 1'b0, "left stream mode")
    u_sep_master.tick(1);
    u_sep_master.cond(1'b0, 1'b0);
    `CHK(bidir_w, 1'b1, "no two-wire mode")
    for (int i = 0; i < 20; i++) begin
      @(negedge strm_w);
      `CHK(oe_w, 1'b0, "stream drive in two-wire mode")
    end
    u_sep_master.run = 1'b0;
    u_sep_master.tick(1);
    for (int t = 0; t < 4; t++) begin
      k = int'(rnd());
      wr(8'(k), NS[t], 1'(t != 3));
      u_sep_master.tick(2);
      `CHK(busy_w, 1'(t != 3), "write cycle start")
      wait_idle();
      rd({k[6:3], 3'h0}, 8);
    end
    wr(8'h3e, 1, 1'b1);
    u_sep_master.tick(2);
    u_sep_master.lvl = 1'b0;
    u_sep_master.cond(1'b0, 1'b1);
    ctl(sep_pkg::DEV_TYPE, 1'b0);
    `CHK(a, 1'b1, "ack while programming")
    u_sep_master.cond(1'b1, 1'b0);
    wait_idle();
    u_sep_master.cond(1'b0, 1'b1);
    ctl(~sep_pkg::DEV_TYPE, 1'b0);
    `CHK(a, 1'b1, "foreign type acked")
    u_sep_master.cond(1'b1, 1'b0);
    rd(7'h3c, 6);
    rd(7'h7c, 6);
    test_done();
  end
endmodule // testbench
`default_nettype wire
